// *** rtl/psc_core.sv ***
// per-port statistics counters fed by receive and transmit frame events
`timescale 1ns/1ps
// Notes on behaviour
// - late collision, past 512 bit times, bumps late-collision count
// - good multicast receive frames counted, broadcast excluded
// - align/code: alignment only at 10M; plus code errors at 100M
// - transmitted multicast frames counted, broadcast excluded
// - successful transmit after more than one collision counted
// - successful transmit after exactly one collision counted
// - net octets adds every received octet, bad frames included
// - well-formed receive frames above 1518, or 1536 long, are oversize
// - all frames except queue-full transmit drops sorted into length buckets 64 through 1023
// - top bucket 1024 to 1518, or to 1536 with long option
// - integral-length receive frame failing check sequence is CRC error
// - short frames with check sequence or alignment error are fragments
// - long frames with check sequence or alignment error are jabbers
// - receive octets adds data and pad of good frames only
// - frame refused by receive FIFO bumps overrun count
// - each PHY signal-quality test error bumps its count
// - select bit picks transmit data error function; low counts queue-full
// - select high counts transmit CRC mismatch or underrun partial frame
// - transmit octets adds data and pad of successful frames
// - well-formed receive frames under 64 octets are undersize
// - statistics addresses 0x980 to 0x9FF reserved, read as zero
// - filtered count takes frames discarded for lack of resources
module psc_core
    import psc_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire logic                       long_frame_en,
    input  wire logic                       tx_error_counter_select,
    input  wire logic                       rx_valid,
    output logic                            rx_ready_r,
    input  wire logic [psc_pkg::PORT_W-1:0] rx_port,
    input  wire logic [psc_pkg::LEN_W-1:0]  rx_len,
    input  wire logic                       rx_fcs_ok,
    input  wire logic                       rx_dribble,
    input  wire logic                       rx_code_err,
    input  wire logic                       rx_speed100,
    input  wire logic                       rx_mcast,
    input  wire logic                       rx_bcast,
    input  wire logic                       rx_overrun,
    input  wire logic                       rx_filtered,
    input  wire logic                       tx_valid,
    output logic                            tx_ready_r,
    input  wire logic [psc_pkg::PORT_W-1:0] tx_port,
    input  wire logic [psc_pkg::LEN_W-1:0]  tx_len,
    input  wire logic                       tx_ok,
    input  wire logic [psc_pkg::COL_W-1:0]  tx_col_cnt,
    input  wire logic                       tx_late_col,
    input  wire logic                       tx_mcast,
    input  wire logic                       tx_bcast,
    input  wire logic                       tx_qfull_drop,
    input  wire logic                       tx_crc_mismatch,
    input  wire logic                       tx_underrun,
    input  wire logic                       tx_sqe_err,
    input  wire logic                       rd_req,
    input  wire logic [psc_pkg::HOST_AW-1:0] rd_addr,
    output logic                            rd_valid_r,
    output logic      [psc_pkg::CNT_W-1:0]  rd_data_r,
    output logic                            busy_r
);
    import psc_pkg::*;

    localparam int                DEPTH    = 1 << MEM_AW;
    localparam logic [MEM_AW-1:0] LAST_ADR = MEM_AW'(DEPTH - 1);
    localparam logic [HOST_AW-1:0] USED_WORDS = HOST_AW'(PORTS << IDX_W);

    function automatic logic [IDX_W-1:0] psc_first(
        input logic [NUM_CNT-1:0] m
    );
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_CNT - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // receive event decode
    wire logic [LEN_W-1:0] max_len;
    wire logic             rx_algn;
    wire logic             rx_crce;
    wire logic             rx_wf;
    wire logic             rx_over;
    wire logic             rx_under;
    wire logic             rx_good;
    wire logic [NUM_CNT-1:0] rx_bkt;
    wire logic [NUM_CNT-1:0] tx_bkt;
    wire logic             tx_sent;

    assign max_len  = long_frame_en ? LEN_MAX_LONG : LEN_MAX_STD;
    assign rx_algn  = rx_dribble & ~rx_fcs_ok;
    assign rx_crce  = ~rx_dribble & ~rx_fcs_ok;
    assign rx_wf    = rx_fcs_ok & ~rx_dribble & ~rx_code_err;
    assign rx_over  = rx_len > max_len;
    assign rx_under = rx_len < LEN_MIN;
    assign rx_good  = rx_wf & ~rx_over & ~rx_under;

    // length buckets shared by both directions
    function automatic logic [NUM_CNT-1:0] psc_bucket(
        input logic [LEN_W-1:0] len,
        input logic [LEN_W-1:0] top
    );
        logic [NUM_CNT-1:0] b;
        b = '0;
        b[C_LEN64]   = len == LEN_MIN;
        b[C_LEN65]   = len >= LEN_65 && len <= LEN_127;
        b[C_LEN128]  = len >= LEN_128 && len <= LEN_255;
        b[C_LEN256]  = len >= LEN_256 && len <= LEN_511;
        b[C_LEN512]  = len >= LEN_512 && len <= LEN_1023;
        b[C_LEN1024] = len >= LEN_1024 && len <= top;
        return b;
    endfunction

    assign rx_bkt  = psc_bucket(rx_len, max_len);
    assign tx_bkt  = psc_bucket(tx_len, max_len);
    assign tx_sent = ~tx_qfull_drop;

    // slot masks are built procedurally below
    logic [NUM_CNT-1:0]      rx_mask;
    logic [NUM_CNT-1:0]      tx_mask;

    // one bit per counter, so each counter moves once per event
    always_comb
    begin
        rx_mask = rx_bkt;
        rx_mask[C_RX_MCAST]    = rx_good & rx_mcast & ~rx_bcast;
        rx_mask[C_RX_ALGNCODE] = rx_algn | (rx_speed100 & rx_code_err);
        rx_mask[C_NET_OCT]     = 1'b1;
        rx_mask[C_OVERSIZE]    = rx_wf & rx_over;
        rx_mask[C_RX_CRC]      = rx_crce;
        rx_mask[C_FRAGMENT]    = rx_under & ~rx_fcs_ok;
        rx_mask[C_JABBER]      = rx_over & ~rx_fcs_ok;
        rx_mask[C_RX_OCT]      = rx_good;
        rx_mask[C_RX_OVERRUN]  = rx_overrun;
        rx_mask[C_UNDERSIZE]   = rx_wf & rx_under;
        rx_mask[C_FILTERED]    = rx_filtered;
    end

    // an all-zero tx mask skips the walk
    always_comb
    begin
        tx_mask = tx_sent ? tx_bkt : '0;
        tx_mask[C_TX_MCAST]   = tx_ok & tx_mcast & ~tx_bcast;
        tx_mask[C_TX_MULTCOL] = tx_ok & (tx_col_cnt > ONE_COL);
        tx_mask[C_TX_SNGLCOL] = tx_ok & (tx_col_cnt == ONE_COL);
        tx_mask[C_LATE_COL]   = tx_late_col;
        tx_mask[C_SQE]        = tx_sqe_err;
        tx_mask[C_TX_DATAERR] = tx_error_counter_select
                              ? (tx_crc_mismatch | tx_underrun)
                              : tx_qfull_drop;
        tx_mask[C_TX_OCT]     = tx_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // event capture and counter walk
    psc_state_t            st_r;
    psc_state_t            st_nxt;
    logic [NUM_CNT-1:0]    mask_r;
    logic [NUM_CNT-1:0]    mask_nxt;
    logic [PORT_W-1:0]     port_r;
    logic [PORT_W-1:0]     port_nxt;
    logic [LEN_W-1:0]      len_r;
    logic [LEN_W-1:0]      len_nxt;
    logic [IDX_W-1:0]      idx_r;
    logic [MEM_AW-1:0]     clr_r;
    logic                  turn_r;
    logic                  rx_ready_nxt;
    logic                  tx_ready_nxt;

    wire logic             take_rx;
    wire logic             take_tx;
    wire logic [IDX_W-1:0] idx_cur;
    wire logic [LEN_W-1:0] pay_len;
    wire logic [CNT_W-1:0] inc;
    wire logic [CNT_W-1:0] mem_q;
    wire logic [CNT_W-1:0] host_q;
    wire logic             mem_we;
    wire logic [MEM_AW-1:0] mem_wa;
    wire logic [CNT_W-1:0] mem_wd;
    wire logic [MEM_AW-1:0] seq_ra;
    wire logic             host_zero;

    assign take_rx = (st_r == ST_IDLE) & rx_valid & rx_ready_r;
    assign take_tx = (st_r == ST_IDLE) & tx_valid & tx_ready_r;
    assign idx_cur = psc_first(mask_r);
    assign seq_ra  = {port_r, idx_cur};
    assign pay_len = (len_r > HDR_FCS_OCT) ? len_r - HDR_FCS_OCT : '0;

    // octet counters add a length, the rest add one
    assign inc = (idx_r == IDX_W'(C_NET_OCT)) ? CNT_W'(len_r)
               : (idx_r == IDX_W'(C_RX_OCT) ||
                  idx_r == IDX_W'(C_TX_OCT)) ? CNT_W'(pay_len)
               : CNT_W'(1);

    assign mem_we = (st_r == ST_CLR) | (st_r == ST_WR);
    assign mem_wa = (st_r == ST_CLR) ? clr_r : {port_r, idx_r};
    assign mem_wd = (st_r == ST_CLR) ? '0 : mem_q + inc;

    always_comb
    begin
        st_nxt   = st_r;
        mask_nxt = mask_r;
        port_nxt = port_r;
        len_nxt  = len_r;
        case (st_r)
            ST_CLR:
            begin
                if (clr_r == LAST_ADR)
                begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (take_rx)
                begin
                    mask_nxt = rx_mask;
                    port_nxt = rx_port;
                    len_nxt  = rx_len;
                    st_nxt   = ST_RD;
                end
                else if (take_tx)
                begin
                    mask_nxt = tx_mask;
                    port_nxt = tx_port;
                    len_nxt  = tx_len;
                    st_nxt   = (tx_mask != '0) ? ST_RD : ST_IDLE;
                end
            end
            ST_RD:
            begin
                st_nxt = ST_WR;
            end
            ST_WR:
            begin
                mask_nxt[idx_r] = 1'b0;
                st_nxt = (mask_nxt == '0) ? ST_IDLE : ST_RD;
            end
            default:
            begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // sources alternate so neither starves the other
    assign rx_ready_nxt = (st_nxt == ST_IDLE) & turn_r;
    assign tx_ready_nxt = (st_nxt == ST_IDLE) & ~turn_r;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            st_r       <= ST_CLR;
            mask_r     <= '0;
            port_r     <= '0;
            len_r      <= '0;
            idx_r      <= '0;
            clr_r      <= '0;
            turn_r     <= 1'b0;
            rx_ready_r <= 1'b0;
            tx_ready_r <= 1'b0;
            busy_r     <= 1'b1;
        end
        else
        begin
            st_r       <= st_nxt;
            mask_r     <= mask_nxt;
            port_r     <= port_nxt;
            len_r      <= len_nxt;
            turn_r     <= ~turn_r;
            rx_ready_r <= rx_ready_nxt;
            tx_ready_r <= tx_ready_nxt;
            busy_r     <= st_nxt != ST_IDLE;
            if (st_r == ST_RD)
            begin
                idx_r <= idx_cur;
            end
            if (st_r == ST_CLR)
            begin
                clr_r <= clr_r + MEM_AW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // statistics read port
    logic rd_pend_r;
    logic rd_zero_r;

    // reserved window and unused words read back as zero
    assign host_zero = (rd_addr >= RSV_LO && rd_addr <= RSV_HI)
                     | (rd_addr >= USED_WORDS);

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rd_pend_r  <= 1'b0;
            rd_zero_r  <= 1'b0;
            rd_valid_r <= 1'b0;
            rd_data_r  <= '0;
        end
        else
        begin
            rd_pend_r  <= rd_req;
            rd_zero_r  <= host_zero;
            rd_valid_r <= rd_pend_r;
            if (rd_pend_r)
            begin
                rd_data_r <= rd_zero_r ? '0 : host_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    psc_mem #(
        .DW (CNT_W),
        .AW (MEM_AW)
    ) u_mem (
        .clk_sys (clk_sys),
        .we      (mem_we),
        .waddr   (mem_wa),
        .wdata   (mem_wd),
        .raddr_a (seq_ra),
        .rdata_a (mem_q),
        .raddr_b (rd_addr[MEM_AW-1:0]),
        .rdata_b (host_q)
    );
endmodule

// *** rtl/psc_mem.sv ***
// counter storage: one write port, two registered read ports
`timescale 1ns/1ps
module psc_mem #(
    parameter int DW = 32,
    parameter int AW = 9
) (
    input  wire logic          clk_sys,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_b
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule

// *** rtl/psc_pkg.sv ***
// constants for the port statistics counters
package psc_pkg;
    localparam int          CNT_W        = 32;
    localparam int          LEN_W        = 14;
    localparam int          PORT_W       = 4;
    localparam int          IDX_W        = 5;
    localparam int          MEM_AW       = PORT_W + IDX_W;
    localparam int          HOST_AW      = 12;
    localparam int          NUM_CNT      = 24;
    localparam int          NUM_PORTS    = 15;
    localparam int          COL_W        = 4;

    // frame length limits, check sequence included
    localparam logic [LEN_W-1:0] LEN_MIN      = 14'h0040;
    localparam logic [LEN_W-1:0] LEN_65       = 14'h0041;
    localparam logic [LEN_W-1:0] LEN_127      = 14'h007F;
    localparam logic [LEN_W-1:0] LEN_128      = 14'h0080;
    localparam logic [LEN_W-1:0] LEN_255      = 14'h00FF;
    localparam logic [LEN_W-1:0] LEN_256      = 14'h0100;
    localparam logic [LEN_W-1:0] LEN_511      = 14'h01FF;
    localparam logic [LEN_W-1:0] LEN_512      = 14'h0200;
    localparam logic [LEN_W-1:0] LEN_1023     = 14'h03FF;
    localparam logic [LEN_W-1:0] LEN_1024     = 14'h0400;
    localparam logic [LEN_W-1:0] LEN_MAX_STD  = 14'h05EE;
    localparam logic [LEN_W-1:0] LEN_MAX_LONG = 14'h0600;
    // addresses, header and check sequence octets
    localparam logic [LEN_W-1:0] HDR_FCS_OCT  = 14'h0012;
    localparam logic [COL_W-1:0] ONE_COL      = 4'h1;

    // statistics address window kept unallocated
    localparam logic [HOST_AW-1:0] RSV_LO     = 12'h980;
    localparam logic [HOST_AW-1:0] RSV_HI     = 12'h9FF;

    // counter slots within a port's block of words
    localparam int C_RX_MCAST    = 0;
    localparam int C_RX_ALGNCODE = 1;
    localparam int C_TX_MCAST    = 2;
    localparam int C_TX_MULTCOL  = 3;
    localparam int C_TX_SNGLCOL  = 4;
    localparam int C_NET_OCT     = 5;
    localparam int C_OVERSIZE    = 6;
    localparam int C_LEN64       = 7;
    localparam int C_LEN65       = 8;
    localparam int C_LEN128      = 9;
    localparam int C_LEN256      = 10;
    localparam int C_LEN512      = 11;
    localparam int C_LEN1024     = 12;
    localparam int C_RX_CRC      = 13;
    localparam int C_FRAGMENT    = 14;
    localparam int C_JABBER      = 15;
    localparam int C_RX_OCT      = 16;
    localparam int C_RX_OVERRUN  = 17;
    localparam int C_SQE         = 18;
    localparam int C_TX_DATAERR  = 19;
    localparam int C_TX_OCT      = 20;
    localparam int C_UNDERSIZE   = 21;
    localparam int C_FILTERED    = 22;
    localparam int C_LATE_COL    = 23;

    typedef enum logic [3:0] {
        ST_CLR  = 4'h1,
        ST_IDLE = 4'h2,
        ST_RD   = 4'h4,
        ST_WR   = 4'h8
    } psc_state_t;
endpackage

// *** tb/psc_chk.sv ***
// port assertions for the statistics counters
`timescale 1ns/1ps
module psc_chk
    import psc_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input wire logic                        clk_sys,
    input wire logic                        reset,
    input wire logic                        rx_valid,
    input wire logic                        rx_ready_r,
    input wire logic                        tx_valid,
    input wire logic                        tx_ready_r,
    input wire logic                        tx_qfull_drop,
    input wire logic [psc_pkg::LEN_W-1:0]   tx_len,
    input wire logic                        busy_r,
    input wire logic                        rd_req,
    input wire logic [psc_pkg::HOST_AW-1:0] rd_addr,
    input wire logic                        rd_valid_r,
    input wire logic [psc_pkg::CNT_W-1:0]   rd_data_r
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////
    sequence s_rx_take;
        rx_valid && rx_ready_r;
    endsequence
    sequence s_tx_bkt;
        tx_valid && tx_ready_r && !tx_qfull_drop && tx_len >= LEN_MIN
            && tx_len <= LEN_1023;
    endsequence
    sequence s_rd_rsv;
        !busy_r && rd_req && rd_addr >= RSV_LO && rd_addr <= RSV_HI;
    endsequence
    ////////////////////////////////////////////////////////////////////
    property p_rx_walk; s_rx_take |=> busy_r [*2]; endproperty
    a_rx_walk: assert property (p_rx_walk) else $error("no rx walk");
    property p_tx_walk; s_tx_bkt |=> busy_r; endproperty
    a_tx_walk: assert property (p_tx_walk) else $error("no tx walk");
    property p_rdy_idle; rx_ready_r || tx_ready_r |-> !busy_r; endproperty
    a_rdy_idle: assert property (p_rdy_idle) else $error("ready busy");
    property p_rdy_alt; rx_ready_r |-> !tx_ready_r ##1 !rx_ready_r;
    endproperty
    a_rdy_alt: assert property (p_rdy_alt) else $error("ready order");
    property p_take;
        (rx_valid && rx_ready_r) || (tx_valid && tx_ready_r)
            |=> !tx_ready_r && (busy_r != rx_ready_r);
    endproperty
    a_take: assert property (p_take) else $error("ready after take");
    property p_sweep; $fell(reset) |-> busy_r [*8]; endproperty
    a_sweep: assert property (p_sweep) else $error("no clear sweep");
    property p_rd_lat; rd_req |-> ##2 rd_valid_r; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read late");
    property p_rd_src; rd_valid_r |-> $past(rd_req, 2); endproperty
    a_rd_src: assert property (p_rd_src) else $error("stray answer");
    property p_rsv; s_rd_rsv |-> ##2 rd_data_r == '0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved not zero");
    property p_hold; !rd_valid_r |-> $stable(rd_data_r); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule

bind psc_core psc_chk #(.PORTS(PORTS)) i_chk (
    .clk_sys(clk_sys), .reset(reset), .rx_valid(rx_valid),
    .rx_ready_r(rx_ready_r), .tx_valid(tx_valid), .tx_ready_r(tx_ready_r),
    .tx_qfull_drop(tx_qfull_drop), .tx_len(tx_len), .busy_r(busy_r),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r)
);

// *** tb/psc_core_tb.sv ***
// self-checking bench for the port statistics counters
`timescale 1ns/1ps
`define CHK(g, x) begin num_checks++; \
    if ((g) !== (x)) begin err_total++; \
    $display("CHECK FAILED %0t got %h want %h", $time, g, x); \
    end end
module psc_core_tb;
    import psc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        lg = 1'b0;
    logic        sel = 1'b0;
    logic        rd_req = 1'b0;
    logic [11:0] rd_addr = '0;
    logic        rx_valid, tx_valid, rx_ready_r, tx_ready_r;
    logic        rd_valid_r, busy_r;
    logic [25:0] rx_ev;
    logic [29:0] tx_ev;
    logic [31:0] rd_data_r;
    logic [31:0] exp_c [15][24];
    int          err_total = 0;
    int          num_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    psc_core i_dut (
        .clk_sys(clk_sys), .reset(reset), .long_frame_en(lg),
        .tx_error_counter_select(sel), .rx_valid(rx_valid),
        .rx_ready_r(rx_ready_r), .rx_port(rx_ev[25:22]),
        .rx_len(rx_ev[21:8]), .rx_fcs_ok(rx_ev[7]), .rx_dribble(rx_ev[6]),
        .rx_code_err(rx_ev[5]), .rx_speed100(rx_ev[4]),
        .rx_mcast(rx_ev[3]), .rx_bcast(rx_ev[2]), .rx_overrun(rx_ev[1]),
        .rx_filtered(rx_ev[0]), .tx_valid(tx_valid),
        .tx_ready_r(tx_ready_r), .tx_port(tx_ev[29:26]),
        .tx_len(tx_ev[25:12]), .tx_ok(tx_ev[11]),
        .tx_col_cnt(tx_ev[10:7]), .tx_late_col(tx_ev[6]),
        .tx_mcast(tx_ev[5]), .tx_bcast(tx_ev[4]),
        .tx_qfull_drop(tx_ev[3]), .tx_crc_mismatch(tx_ev[2]),
        .tx_underrun(tx_ev[1]), .tx_sqe_err(tx_ev[0]), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_valid_r(rd_valid_r),
        .rd_data_r(rd_data_r), .busy_r(busy_r)
    );

    psc_mac_model i_mac (
        .clk_sys(clk_sys), .rx_ready_r(rx_ready_r),
        .tx_ready_r(tx_ready_r), .rx_valid(rx_valid), .rx_ev(rx_ev),
        .tx_valid(tx_valid), .tx_ev(tx_ev)
    );
    ////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] bk(logic [13:0] l, logic [13:0] mx);
        bk = '0;
        bk[C_LEN64] = l == LEN_MIN;
        bk[C_LEN65] = l >= LEN_65 && l <= LEN_127;
        bk[C_LEN128] = l >= LEN_128 && l <= LEN_255;
        bk[C_LEN256] = l >= LEN_256 && l <= LEN_511;
        bk[C_LEN512] = l >= LEN_512 && l <= LEN_1023;
        bk[C_LEN1024] = l >= LEN_1024 && l <= mx;
    endfunction

    function automatic logic [23:0] msk(logic tx, logic [29:0] e);
        logic [13:0] l;
        logic [13:0] mx;
        logic        wf;
        logic        gd;
        logic [23:0] m;
        mx = lg ? LEN_MAX_LONG : LEN_MAX_STD;
        l = tx ? e[25:12] : e[21:8];
        wf = e[7] & !e[6] & !e[5];
        gd = wf && l >= LEN_MIN && l <= mx;
        m = (tx && e[3]) ? '0 : bk(l, mx);
        if (tx)
        begin
            m[C_TX_MCAST] = e[11] & e[5] & !e[4];
            m[C_TX_MULTCOL] = e[11] && e[10:7] > ONE_COL;
            m[C_TX_SNGLCOL] = e[11] && e[10:7] == ONE_COL;
            m[C_SQE] = e[0];
            m[C_TX_DATAERR] = sel ? e[2] | e[1] : e[3];
            m[C_TX_OCT] = e[11];
            m[C_LATE_COL] = e[6];
        end
        else
        begin
            m[C_RX_MCAST] = gd & e[3] & !e[2];
            m[C_RX_ALGNCODE] = (!e[7] & e[6]) | (e[4] & e[5]);
            m[C_NET_OCT] = 1'b1;
            m[C_OVERSIZE] = wf && l > mx;
            m[C_RX_CRC] = !e[7] & !e[6];
            m[C_FRAGMENT] = !e[7] && l < LEN_MIN;
            m[C_JABBER] = !e[7] && l > mx;
            m[C_RX_OCT] = gd;
            m[C_RX_OVERRUN] = e[1];
            m[C_UNDERSIZE] = wf && l < LEN_MIN;
            m[C_FILTERED] = e[0];
        end
        return m;
    endfunction

    task automatic upd(logic tx, logic [29:0] e, logic [23:0] m);
        logic [3:0]  p;
        logic [31:0] l;
        logic [31:0] d;
        p = tx ? e[29:26] : e[25:22];
        l = tx ? e[25:12] : e[21:8];
        for (int s = 0; s < NUM_CNT; s++)
        begin
            d = 32'h1;
            if (s == C_NET_OCT)
                d = l;
            if (s == C_RX_OCT || s == C_TX_OCT)
                d = l > HDR_FCS_OCT ? l - HDR_FCS_OCT : '0;
            if (m[s])
                exp_c[p][s] += d;
        end
    endtask

    function automatic logic [13:0] rlen();
        logic [13:0] t [12];
        t = '{14'h003F, 14'h0040, 14'h0041, 14'h00FF, 14'h0100, 14'h03FF,
              14'h0400, 14'h05EE, 14'h05EF, 14'h0600, 14'h0601, 14'h0080};
        if ($urandom % 2)
            return t[$urandom % 12];
        return 14'($urandom_range(1600, 1));
    endfunction
    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tmo();
        err_total++;
        give_verdict();
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_r !== 1'b0)
        begin
            @(negedge clk_sys);
            n++;
            if (n > 1000)
                tmo();
        end
    endtask

    task automatic rd(int a, logic [31:0] x);
        int n;
        n = 0;
        @(negedge clk_sys);
        rd_req = 1'b1;
        rd_addr = 12'(a);
        @(negedge clk_sys);
        rd_req = 1'b0;
        while (rd_valid_r !== 1'b1 && n < 8)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 8)
            tmo();
        `CHK(rd_data_r, x)
    endtask

    task automatic rd_all();
        for (int p = 0; p < NUM_PORTS; p++)
            for (int s = 0; s < NUM_CNT; s++)
                rd(p * 32 + s, exp_c[p][s]);
        rd(RSV_LO, '0);
        rd(RSV_HI, '0);
        rd(NUM_PORTS * 32, '0);
    endtask

    task automatic do_reset();
        reset = 1'b1;
        exp_c = '{default: '0};
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        wait_idle();
    endtask

    task automatic run_ev(logic tx, logic [29:0] e);
        logic        ok;
        logic [23:0] m;
        m = msk(tx, e);
        i_mac.send(tx, e, ok);
        if (!ok)
            tmo();
        @(negedge clk_sys);
        wait_idle();
        upd(tx, e, m);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] r;
        logic [29:0] e;
        logic [3:0]  p;
        void'($urandom(32'hD20B));
        do_reset();
        sel = 1'b1;
        // jabber, empty tx event, single collision, minimum-length multicast
        run_ev(1'b0, {4'h0, 4'hE, 14'h05EF, 8'h00});
        run_ev(1'b1, {4'h0, 14'h0040, 12'h008});
        run_ev(1'b1, {4'h3, 14'h05EE, 12'h880});
        run_ev(1'b0, {4'h0, 4'h3, 14'h0040, 8'h98});
        for (int i = 0; i < 500; i++)
        begin
            if (i % 64 == 0)
            begin
                lg = 1'($urandom);
                sel = 1'($urandom);
            end
            r = $urandom;
            p = 4'($urandom_range(14, 0));
            if (r[31])
                e = {p, rlen(), r[0], 2'b00, r[2:1], r[3], r[6] & r[0],
                     r[8], r[7] & !r[0], r[11:9]};
            else
                e = {4'h0, p, rlen(), r[0] | r[1], r[2] & r[3], r[4] & r[5],
                     r[6], r[7], r[8] & r[9], &r[12:10], &r[15:13]};
            run_ev(r[31], e);
        end
        rd_all();
        do_reset();
        rd_all();
        give_verdict();
    end
endmodule

// *** tb/psc_mac_model.sv ***
// partner model: MAC ports offering frame events
`timescale 1ns/1ps
module psc_mac_model (
    input  wire logic        clk_sys,
    input  wire logic        rx_ready_r,
    input  wire logic        tx_ready_r,
    output logic             rx_valid,
    output logic      [25:0] rx_ev,
    output logic             tx_valid,
    output logic      [29:0] tx_ev
);
    initial
    begin
        rx_valid = 1'b0;
        tx_valid = 1'b0;
        rx_ev = '0;
        tx_ev = '0;
    end

    // one event per frame, held until taken, lines scrambled after
    task automatic send(input logic tx, input logic [29:0] ev,
                        output logic ok);
        int n;
        n = 0;
        @(negedge clk_sys);
        rx_ev = ev[25:0];
        tx_ev = ev;
        rx_valid = !tx;
        tx_valid = tx;
        while ((tx ? tx_ready_r : rx_ready_r) !== 1'b1 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        ok = n < 3000;
        @(negedge clk_sys);
        rx_valid = 1'b0;
        tx_valid = 1'b0;
        rx_ev = ~rx_ev;
        tx_ev = ~tx_ev;
    endtask
endmodule
